// ### hdl/vsc_map.svh
`ifndef VSC_MAP_SVH
`define VSC_MAP_SVH

// ==========================================================================
// Register subaddresses.
`define VSC_ADDR_HSB    8'h06
`define VSC_ADDR_HSS    8'h07
`define VSC_ADDR_SYNC   8'h08

// ==========================================================================
// Reset values.
`define VSC_HSB_RST     8'he9
`define VSC_HSS_RST     8'h0d
`define VSC_SYNC_RST    8'h98

// ==========================================================================
// Sync control field positions.
`define VSC_AUTO_FIELD_DETECT_BIT    7
`define VSC_MANUAL_FIELD_RATE_BIT    6
`define VSC_FORCED_PARITY_TOGGLE_BIT    5
`define VSC_HTC_MSB     4
`define VSC_HTC_LSB     3
`define VSC_HORIZ_LOOP_OPEN_BIT    2
`define VSC_VNOI_MSB    1
`define VSC_VNOI_LSB    0

// ==========================================================================
// Horizontal delay encoding.
`define VSC_STEP_SHIFT  3
`define VSC_LIM_50      8'sh6c
`define VSC_LIM_60      8'sh6b

// ==========================================================================
// Vertical timing in half lines per field, and vertical sync miss limits.
`define VSC_HL_50       10'h271
`define VSC_HL_60       10'h20d
`define VSC_HL_SPLIT    10'h23f
`define VSC_VWIN        10'h004
`define VSC_VMISS_NORM  2'h3
`define VSC_VMISS_FAST  2'h1

// ==========================================================================
// Horizontal loop misses tolerated before realignment.
`define VSC_TC_TV_MISS  2'h3
`define VSC_TC_VTR_MISS 2'h1

`endif

// ### hdl/vsc_pkg.sv
package vsc_pkg;

  typedef enum logic [1:0] {VSC_TC_TV, VSC_TC_VTR, VSC_TC_RSVD, VSC_TC_FAST} vsc_tc_t;

  typedef enum logic [1:0] {VSC_VN_NORMAL, VSC_VN_FAST, VSC_VN_FREE, VSC_VN_BYPASS} vsc_vn_t;

  typedef enum {VSC_V_SEARCH, VSC_V_LOCK} vsc_vstate_t;

endpackage

// ### hdl/vsc_line_timer.sv
`timescale 1ns/10ps
`include "vsc_map.svh"

module vsc_line_timer
  import vsc_pkg::*;
#(
  parameter int LINE_CLKS = 1728,
  parameter int POS_W     = 11
)
(
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             hsync_in_i,
  input  wire logic             loop_open_i,
  input  wire vsc_tc_t          tc_i,
  output logic [POS_W-1:0]      pos_o,
  output logic                  realign_o
);

  localparam logic [POS_W-1:0] LAST = POS_W'(LINE_CLKS - 1);

  logic [1:0] miss_q;
  logic [1:0] limit;
  logic       sync_off;

  generate
    if (LINE_CLKS < 2 || LINE_CLKS > (1 << POS_W))
    begin : g_bad_len
      $error("vsc_line_timer: LINE_CLKS does not fit POS_W");
    end
  endgenerate

  // ========================================================================
  // Loop time constant as a count of tolerated phase misses.
  always_comb
  begin
    case (tc_i)
      VSC_TC_TV:  limit = `VSC_TC_TV_MISS;
      VSC_TC_VTR: limit = `VSC_TC_VTR_MISS;
      default:    limit = 2'h0;
    endcase
  end

  assign sync_off  = hsync_in_i && !loop_open_i && (pos_o != '0);
  assign realign_o = sync_off && (miss_q >= limit);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      miss_q <= 2'h0;
    else if (hsync_in_i && !loop_open_i)
    begin
      if (!sync_off || realign_o)
        miss_q <= 2'h0;
      else
        miss_q <= miss_q + 2'h1;
    end
  end

  // ========================================================================
  // Line position counter; a realignment puts the sync edge at position 0.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pos_o <= '0;
    else if (realign_o)
      pos_o <= POS_W'(1);
    else if (pos_o == LAST)
      pos_o <= '0;
    else
      pos_o <= pos_o + POS_W'(1);
  end

endmodule

// ### hdl/vsc_sync_ctrl.sv
`timescale 1ns/10ps
`include "vsc_map.svh"

module vsc_sync_ctrl
  import vsc_pkg::*;
#(
  parameter int LINE_CLKS = 1728
)
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic [7:0]      reg_rdata_o,
  input  wire logic       hsync_in_i,
  input  wire logic       vsync_in_i,
  output logic            hsync_o,
  output logic            vsync_o,
  output logic            odd_even_o,
  output logic            field_60hz_o,
  output logic            interlaced_o,
  output logic            vert_locked_o
);

  localparam int POS_W  = 11;
  localparam int CENTER = LINE_CLKS / 2;
  localparam logic [POS_W-1:0] HALF = POS_W'(CENTER);

  generate
    if (CENTER < 864 || CENTER + 864 > LINE_CLKS || LINE_CLKS > 2047)
    begin : g_bad_len
      $error("vsc_sync_ctrl: LINE_CLKS cannot hold the delay range");
    end
  endgenerate

  logic [7:0]       hsb_q;
  logic [7:0]       hss_q;
  logic [7:0]       sync_q;
  logic [POS_W-1:0] pos;
  logic             realign;
  logic             auto_field_detect;
  logic             manual_field_rate;
  logic             forced_parity_toggle;
  logic             horiz_loop_open;
  vsc_tc_t          horiz_time_constant;
  vsc_vn_t          vert_noise_mode;
  logic             det60_q;
  logic             rate60;
  logic [11:0]      start_pos;
  logic [11:0]      stop_pos;
  logic             in_window;
  logic [9:0]       hl_q;
  logic [9:0]       exp_hl;
  logic             half_tick;
  logic             in_win;
  logic             fly_edge;
  logic             evt;
  logic             miss_evt;
  logic [1:0]       vmiss_q;
  logic [1:0]       vmiss_lim;
  vsc_vstate_t      vstate_q;
  logic             il_now;

  // ========================================================================
  // Register file.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hsb_q  <= `VSC_HSB_RST;
      hss_q  <= `VSC_HSS_RST;
      sync_q <= `VSC_SYNC_RST;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `VSC_ADDR_HSB:  hsb_q  <= reg_wdata_i;
        `VSC_ADDR_HSS:  hss_q  <= reg_wdata_i;
        `VSC_ADDR_SYNC: sync_q <= reg_wdata_i;
        default:        ;
      endcase
    end
  end

  // Read data is registered; unmapped subaddresses read as zero.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `VSC_ADDR_HSB:  reg_rdata_o <= hsb_q;
        `VSC_ADDR_HSS:  reg_rdata_o <= hss_q;
        `VSC_ADDR_SYNC: reg_rdata_o <= sync_q;
        default:        reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign auto_field_detect    = sync_q[`VSC_AUTO_FIELD_DETECT_BIT];
  assign manual_field_rate    = sync_q[`VSC_MANUAL_FIELD_RATE_BIT];
  assign forced_parity_toggle = sync_q[`VSC_FORCED_PARITY_TOGGLE_BIT];
  assign horiz_time_constant  = vsc_tc_t'(sync_q[`VSC_HTC_MSB:`VSC_HTC_LSB]);
  assign horiz_loop_open      = sync_q[`VSC_HORIZ_LOOP_OPEN_BIT];
  assign vert_noise_mode      = vsc_vn_t'(sync_q[`VSC_VNOI_MSB:`VSC_VNOI_LSB]);

  assign rate60 = auto_field_detect ? det60_q : manual_field_rate;
  assign exp_hl = rate60 ? `VSC_HL_60 : `VSC_HL_50;

  // ========================================================================
  // Horizontal loop and sync window.
  vsc_line_timer #(
    .LINE_CLKS (LINE_CLKS),
    .POS_W     (POS_W)
  ) u_line_timer (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .hsync_in_i  (hsync_in_i),
    .loop_open_i (horiz_loop_open),
    .tc_i        (horiz_time_constant),
    .pos_o       (pos),
    .realign_o   (realign)
  );

  // Out-of-range delays are clamped so the window never leaves the counter.
  function automatic logic [11:0] win_pos(input logic signed [7:0] d, input logic is60);
    logic signed [7:0] lim;
    logic signed [7:0] c;
    lim = is60 ? `VSC_LIM_60 : `VSC_LIM_50;
    c   = (d > lim) ? lim : ((d < -lim) ? -lim : d);
    return 12'(CENTER) + ({{4{c[7]}}, c} << `VSC_STEP_SHIFT);
  endfunction

  assign start_pos = win_pos(hsb_q, rate60);
  assign stop_pos  = win_pos(hss_q, rate60);
  assign in_window = ({1'b0, pos} >= start_pos) && ({1'b0, pos} < stop_pos);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hsync_o <= 1'b0;
    else
      hsync_o <= in_window;
  end

  // ========================================================================
  // Vertical processing in half-line units.
  assign half_tick = (pos == '0) || (pos == HALF);
  assign in_win    = (hl_q + `VSC_VWIN >= exp_hl) && (hl_q <= exp_hl + `VSC_VWIN);
  assign fly_edge  = half_tick && (hl_q == exp_hl + `VSC_VWIN);
  assign vmiss_lim = (vert_noise_mode == VSC_VN_FAST) ? `VSC_VMISS_FAST : `VSC_VMISS_NORM;

  always_comb
  begin
    miss_evt = 1'b0;
    case (vert_noise_mode)
      VSC_VN_BYPASS: evt = vsync_in_i;
      VSC_VN_FREE:   evt = half_tick && (hl_q == exp_hl - 10'h001);
      default:
      begin
        if (vstate_q == VSC_V_LOCK)
        begin
          evt      = (vsync_in_i && in_win) || fly_edge;
          miss_evt = (fly_edge && !vsync_in_i) || (vsync_in_i && !in_win);
        end
        else
          evt = vsync_in_i;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hl_q <= 10'h000;
    else if (evt)
      hl_q <= 10'h000;
    else if (half_tick && hl_q != 10'h3ff)
      hl_q <= hl_q + 10'h001;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vstate_q <= VSC_V_SEARCH;
      vmiss_q  <= 2'h0;
    end
    else if (vert_noise_mode == VSC_VN_BYPASS || vert_noise_mode == VSC_VN_FREE)
    begin
      vstate_q <= VSC_V_SEARCH;
      vmiss_q  <= 2'h0;
    end
    else
    begin
      case (vstate_q)
        VSC_V_SEARCH:
        begin
          vmiss_q <= 2'h0;
          if (vsync_in_i)
            vstate_q <= VSC_V_LOCK;
        end
        VSC_V_LOCK:
        begin
          if (miss_evt && vmiss_q + 2'h1 >= vmiss_lim)
          begin
            vstate_q <= VSC_V_SEARCH;
            vmiss_q  <= 2'h0;
          end
          else if (miss_evt)
            vmiss_q <= vmiss_q + 2'h1;
          else if (vsync_in_i && in_win)
            vmiss_q <= 2'h0;
        end
        default: vstate_q <= VSC_V_SEARCH;
      endcase
    end
  end

  assign vert_locked_o = (vstate_q == VSC_V_LOCK);

  // Field rate and interlace are measured only on fields ended by real sync.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      det60_q      <= 1'b0;
      interlaced_o <= 1'b0;
    end
    else if (evt && vsync_in_i)
    begin
      interlaced_o <= hl_q[0];
      if (auto_field_detect)
        det60_q <= (hl_q <= `VSC_HL_SPLIT);
    end
  end

  assign il_now = vsync_in_i ? hl_q[0] : interlaced_o;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vsync_o    <= 1'b0;
      odd_even_o <= 1'b0;
    end
    else
    begin
      vsync_o <= evt;
      if (evt && (forced_parity_toggle || il_now))
        odd_even_o <= !odd_even_o;
    end
  end

  assign field_60hz_o = rate60;

  // ========================================================================
  // Assertions.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_field_end;
    evt && vsync_in_i;
  endsequence

  sequence s_toggle_cause;
    evt && (forced_parity_toggle || il_now);
  endsequence

  a_stop_edge: assert property ($fell(hsync_o) |-> $past(pos) == $past(stop_pos[POS_W-1:0])
    || $past(pos) == POS_W'(LINE_CLKS - 1) || $past(pos) == '0
    || $changed($past(stop_pos)) || $changed($past(start_pos)) || $past(realign, 2))
    else $error("sync window closed away from stop position");
  a_stop_range: assert property (stop_pos >= 12'(CENTER - 864) && stop_pos <= 12'(CENTER + 864))
    else $error("sync stop position outside central range");
  a_auto_rate: assert property ((s_field_end and auto_field_detect) ##1 auto_field_detect
    |-> field_60hz_o == ($past(hl_q) <= `VSC_HL_SPLIT))
    else $error("detected field rate wrong");
  a_manual_rate: assert property (!auto_field_detect |-> field_60hz_o == manual_field_rate
    && exp_hl == (manual_field_rate ? `VSC_HL_60 : `VSC_HL_50))
    else $error("manual field rate not applied");
  a_parity_flip: assert property (s_toggle_cause |=> odd_even_o != $past(odd_even_o))
    else $error("parity did not toggle");
  a_parity_hold: assert property (evt && !forced_parity_toggle && !il_now |=> $stable(odd_even_o))
    else $error("parity toggled for progressive input");
  a_fast_lock: assert property (horiz_time_constant == VSC_TC_FAST && !horiz_loop_open
    && hsync_in_i && pos != '0 |=> pos == POS_W'(1))
    else $error("fast lock did not realign");
  a_loop_open: assert property (horiz_loop_open |-> !realign)
    else $error("open loop realigned the line counter");
  a_vnr_bypass: assert property (vert_noise_mode == VSC_VN_BYPASS && vsync_in_i |=> vsync_o)
    else $error("bypassed vertical sync not passed");
  a_free_run: assert property (vert_noise_mode == VSC_VN_FREE && vsync_o
    |-> $past(hl_q) == exp_hl - 10'h001)
    else $error("free running field length wrong");
  a_start_range: assert property (start_pos >= 12'(CENTER - 864) && start_pos <= 12'(CENTER + 864))
    else $error("sync start position outside central range");
  a_manual_ignored: assert property (auto_field_detect && $past(auto_field_detect)
    && $changed(manual_field_rate) && !$past(evt && vsync_in_i) |-> $stable(field_60hz_o))
    else $error("manual rate affected auto detection");

endmodule

// ### bench/vsc_host_model.sv
`timescale 1ns/10ps
// ==========================================================================
// Host controller on the register port.
module vsc_host_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_rd_o
);
  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  // Released address and data are inverted so stale values are never reused.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    @(posedge clk_i);
    #1;
    d = reg_rdata_i;
  endtask

  task automatic set_delay(input logic [7:0] a, input int v, input logic r60);
    int lim;
    lim = r60 ? 107 : 108;
    if (v > lim)
      v = lim;
    if (v < -lim)
      v = -lim;
    wr(a, 8'(v));
  endtask

  task automatic set_sync(input logic [7:0] v);
    if (v[1:0] == 2'h1)
      v[7] = 1'b0;
    wr(8'h08, v);
  endtask
endmodule

// ### bench/test_video_sync_control.sv
`timescale 1ns/10ps
`include "vsc_map.svh"
// ==========================================================================
// Self-checking bench for the sync controller.
module test_video_sync_control;
  logic       clk;
  logic       reset_n;
  logic       hs_in;
  logic       vs_in;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       hs;
  logic       vs;
  logic       odd_even;
  logic       rate60;
  logic       intl;
  logic       locked;
  int         miscompares;
  int         compares;

  vsc_sync_ctrl #(.LINE_CLKS(1728)) uut
  (
    .clk_i         (clk),
    .reset_n_i     (reset_n),
    .reg_addr_i    (addr),
    .reg_wr_i      (wr),
    .reg_wdata_i   (wdata),
    .reg_rd_i      (rd),
    .reg_rdata_o   (rdata),
    .hsync_in_i    (hs_in),
    .vsync_in_i    (vs_in),
    .hsync_o       (hs),
    .vsync_o       (vs),
    .odd_even_o    (odd_even),
    .field_60hz_o  (rate60),
    .interlaced_o  (intl),
    .vert_locked_o (locked)
  );

  vsc_host_model host
  (
    .clk_i       (clk),
    .reg_rdata_i (rdata),
    .reg_addr_o  (addr),
    .reg_wr_o    (wr),
    .reg_wdata_o (wdata),
    .reg_rd_o    (rd)
  );

  initial
  begin
    clk = 1'b0;
    forever
      #20 clk = ~clk;
  end

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d === e, "register read");
  endtask

  // Sends k line syncs and times the window from the last one.
  task automatic htime(input int k, output int r, output int w);
    r = 0;
    w = 0;
    repeat (k)
    begin
      repeat (8) @(posedge clk);
      #1;
      hs_in = 1'b1;
      @(posedge clk);
      #1;
      hs_in = 1'b0;
    end
    while ((hs !== 1'b1 || r == 0) && r < 4000)
    begin
      @(posedge clk);
      #1;
      r++;
    end
    while (hs === 1'b1 && w < 4000)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    if (r >= 4000 || w >= 4000)
    begin
      miscompares++;
      $display("BAD %0t window wait ran out", $time);
      end_of_test();
    end
  endtask

  task automatic vpulse(output logic s);
    @(posedge clk);
    #1;
    vs_in = 1'b1;
    @(posedge clk);
    #1;
    vs_in = 1'b0;
    s = vs;
    @(posedge clk);
    #1;
    s = s | vs;
  endtask

  initial
  begin
    logic s;
    logic oe;
    int   r;
    int   w;
    miscompares = 0;
    compares = 0;
    reset_n = 1'b0;
    hs_in = 1'b0;
    vs_in = 1'b0;
    repeat (6) @(posedge clk);
    chk({hs, vs, odd_even, rate60, intl, locked} === 6'h00, "reset outputs");
    #1;
    reset_n = 1'b1;
    rchk(`VSC_ADDR_HSB, `VSC_HSB_RST);
    rchk(`VSC_ADDR_HSS, `VSC_HSS_RST);
    rchk(`VSC_ADDR_SYNC, `VSC_SYNC_RST);
    host.wr(8'h05, 8'h5a);
    rchk(8'h05, 8'h00);
    host.set_sync(8'hc8);
    chk(rate60 === 1'b0, "manual rate used in auto");
    host.set_sync(8'h58);
    chk(rate60 === 1'b1, "manual 60 Hz");
    host.set_sync(8'h18);
    chk(rate60 === 1'b0, "manual 50 Hz");
    htime(1, r, w);
    chk(r === 680 && w === 288, "reset window");
    host.set_delay(`VSC_ADDR_HSB, -104, 1'b0);
    host.set_delay(`VSC_ADDR_HSS, -100, 1'b0);
    htime(1, r, w);
    chk(r === 32 && w === 32, "negative window");
    host.set_delay(`VSC_ADDR_HSS, 108, 1'b0);
    rchk(`VSC_ADDR_HSS, 8'h6c);
    htime(1, r, w);
    chk(w === 1696, "50 Hz stop limit");
    host.set_sync(8'h58);
    host.set_delay(`VSC_ADDR_HSS, 107, 1'b1);
    htime(1, r, w);
    chk(w === 1688, "60 Hz stop limit");
    host.set_sync(8'h1c);
    host.set_delay(`VSC_ADDR_HSS, -100, 1'b0);
    htime(1, r, w);
    chk(r !== 32, "open loop followed sync");
    host.set_sync(8'h00);
    htime(1, r, w);
    chk(r !== 32, "slow loop jumped at once");
    htime(3, r, w);
    chk(r === 32, "slow loop no realign");
    host.set_sync(8'h08);
    htime(1, r, w);
    chk(r !== 32, "tape loop jumped at once");
    htime(1, r, w);
    chk(r === 32, "tape loop no realign");
    host.set_sync(8'h10);
    htime(1, r, w);
    chk(r === 32, "reserved loop no realign");
    host.set_sync(8'h18);
    vpulse(s);
    chk(s === 1'b1 && locked === 1'b1, "search lock");
    repeat (100) @(posedge clk);
    vpulse(s);
    chk(s === 1'b0 && locked === 1'b1, "stray pulse");
    host.set_sync(8'h99);
    rchk(`VSC_ADDR_SYNC, 8'h19);
    vpulse(s);
    repeat (2) @(posedge clk);
    chk(s === 1'b0 && locked === 1'b0, "fast mode lock");
    host.set_sync(8'h1b);
    vpulse(s);
    chk(s === 1'b1, "bypass pulse");
    repeat (1725) @(posedge clk);
    vpulse(s);
    oe = odd_even;
    repeat (1725) @(posedge clk);
    vpulse(s);
    chk(intl === 1'b0 && odd_even === oe, "even field parity");
    repeat (861) @(posedge clk);
    vpulse(s);
    oe = odd_even;
    repeat (861) @(posedge clk);
    vpulse(s);
    chk(intl === 1'b1 && odd_even === ~oe, "odd field parity");
    host.set_sync(8'h3b);
    vpulse(s);
    oe = odd_even;
    repeat (1725) @(posedge clk);
    vpulse(s);
    chk(intl === 1'b0 && odd_even === ~oe, "forced parity");
    host.set_sync(8'h1a);
    vpulse(s);
    chk(s === 1'b0, "free run input");
    host.set_sync(8'h9b);
    vpulse(s);
    chk(rate60 === 1'b1, "auto rate detect");
    end_of_test();
  end
endmodule
